// ---- src/cbu_top.sv ----
// Operation
// - Unsigned above: carry set, zero clear
// - Signed at most: zero, or N differs OV
// - Unsigned at most: carry clear or zero
// - Signed below: N differs from OV
// - Target is PC plus two plus 2*offset
// - Taken branch squashes next slot with no-op
// - Basic: one cycle untaken, two taken
// - Enhanced: one cycle untaken, four taken
// - Offset is full 16-bit two's complement
// - Offset counts instruction words, 32K reach
// - Offset measured from following instruction
`timescale 1ns/100ps
module cbu_top
#(
  parameter bit ENHANCED = 1'b0,
  parameter int unsigned PC_W = 24,
  parameter int unsigned INSN_W = 24
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic insn_valid,
  input wire logic [INSN_W-1:0] insn_word,
  input wire logic [PC_W-1:0] insn_pc,
  input wire logic flag_c,
  input wire logic flag_z,
  input wire logic flag_n,
  input wire logic flag_ov,
  output logic pc_load_r,
  output logic [PC_W-1:0] pc_target_r,
  output logic squash_r,
  output logic [INSN_W-1:0] ir_nop_r,
  output logic stall_r,
  output logic branch_done_r,
  output logic branch_taken_r
);

  // ----------------------------------------
  // Decode and condition test
  // ----------------------------------------
  localparam int unsigned TAKEN_CYCLES =
    ENHANCED ? cbu_pkg::TAKEN_CYCLES_ENHANCED : cbu_pkg::TAKEN_CYCLES_BASIC;
  localparam logic [1:0] EXTRA_SLOTS = 2'(TAKEN_CYCLES - 1);

  typedef enum logic [1:0]
  {
    CBU_IDLE,
    CBU_FLUSH
  } cbu_state_type;

  cbu_state_type state_r;
  logic [1:0] slot_cnt_r;
  logic is_branch;
  logic cond_true;
  logic accept;
  logic take;
  logic [PC_W-1:0] target;

  // Flags are inputs only; nothing here can write them
  cbu_cond_eval u_cond
  (
    .op_hi(insn_word[cbu_pkg::OP_HI_MSB:cbu_pkg::OP_HI_LSB]),
    .op_lo(insn_word[cbu_pkg::OP_LO_MSB:cbu_pkg::OP_LO_LSB]),
    .flag_c(flag_c),
    .flag_z(flag_z),
    .flag_n(flag_n),
    .flag_ov(flag_ov),
    .is_branch(is_branch),
    .cond_true(cond_true)
  );

  cbu_target #(.PC_W(PC_W), .OFFSET_W(cbu_pkg::OFFSET_W)) u_target
  (
    .pc(insn_pc),
    .offset(insn_word[cbu_pkg::OFF_MSB:cbu_pkg::OFF_LSB]),
    .target(target)
  );

  // New branches are ignored while a taken one still occupies slots
  assign accept = insn_valid && is_branch && (state_r == CBU_IDLE);
  assign take = accept && cond_true;

  // ----------------------------------------
  // Slot sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= CBU_IDLE;
      slot_cnt_r <= cbu_pkg::CNT_ZERO;
    end
    else
    begin
      case (state_r)
        CBU_IDLE:
        begin
          if (take)
          begin
            state_r <= CBU_FLUSH;
            slot_cnt_r <= EXTRA_SLOTS;
          end
        end
        CBU_FLUSH:
        begin
          if (slot_cnt_r == cbu_pkg::CNT_ONE)
          begin
            state_r <= CBU_IDLE;
            slot_cnt_r <= cbu_pkg::CNT_ZERO;
          end
          else
          begin
            slot_cnt_r <= slot_cnt_r - cbu_pkg::CNT_ONE;
          end
        end
        default:
        begin
          state_r <= CBU_IDLE;
          slot_cnt_r <= cbu_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Program counter load
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pc_load_r <= 1'b0;
      pc_target_r <= cbu_pkg::PC_RESET;
    end
    else
    begin
      pc_load_r <= take;
      if (take)
      begin
        pc_target_r <= target;
      end
    end
  end

  // ----------------------------------------
  // Squash and stall
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      squash_r <= 1'b0;
      stall_r <= 1'b0;
      ir_nop_r <= cbu_pkg::NOP_WORD;
    end
    else
    begin
      // Fetched follower is replaced by a no-op in the extra slot
      squash_r <= take;
      ir_nop_r <= cbu_pkg::NOP_WORD;
      stall_r <= take || ((state_r == CBU_FLUSH) && (slot_cnt_r != cbu_pkg::CNT_ONE));
    end
  end

  // ----------------------------------------
  // Completion report
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      branch_done_r <= 1'b0;
      branch_taken_r <= 1'b0;
    end
    else
    begin
      branch_done_r <= (accept && !cond_true) || ((state_r == CBU_FLUSH) && (slot_cnt_r == cbu_pkg::CNT_ONE));
      if (accept)
      begin
        branch_taken_r <= cond_true;
      end
    end
  end

  // ----------------------------------------
  // Assertion helpers
  // ----------------------------------------
  // Stall run length, so its bound can follow the variant
  logic [1:0] stall_run_r;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stall_run_r <= cbu_pkg::CNT_ZERO;
    end
    else if (stall_r)
    begin
      stall_run_r <= stall_run_r + cbu_pkg::CNT_ONE;
    end
    else
    begin
      stall_run_r <= cbu_pkg::CNT_ZERO;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  above_cond_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (insn_valid && state_r == CBU_IDLE && insn_word[23:16] == 8'h3E) |=> (pc_load_r == ($past(flag_c) && !$past(flag_z))))
    else $error("unsigned above condition wrong");

  at_most_cond_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (insn_valid && state_r == CBU_IDLE && insn_word[23:16] == 8'h34)
      |=> (pc_load_r == ($past(flag_z) || ($past(flag_n) != $past(flag_ov)))))
    else $error("signed at most condition wrong");

  unsigned_most_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (insn_valid && state_r == CBU_IDLE && insn_word[23:16] == 8'h36) |=> (pc_load_r == (!$past(flag_c) || $past(flag_z))))
    else $error("unsigned at most condition wrong");

  below_cond_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (insn_valid && state_r == CBU_IDLE && insn_word[23:16] == 8'h35) |=> (pc_load_r == ($past(flag_n) != $past(flag_ov))))
    else $error("signed below condition wrong");

  target_calc_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    take |=> (pc_target_r == PC_W'($past(insn_pc) + 2 + {{(PC_W-17){$past(insn_word[15])}}, $past(insn_word[15:0]), 1'b0})))
    else $error("branch target wrong");

  squash_nop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    take |=> (squash_r && ir_nop_r == cbu_pkg::NOP_WORD))
    else $error("no squash after taken branch");

  if (ENHANCED)
  begin : g_enh_len
    taken_len_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      take |=> stall_r [*3] ##1 (!stall_r && branch_done_r))
      else $error("taken branch length wrong");
  end
  else
  begin : g_basic_len
    taken_len_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      take |=> stall_r ##1 (!stall_r && branch_done_r))
      else $error("taken branch length wrong");
  end

  untaken_one_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (accept && !cond_true) |=> (branch_done_r && !stall_r && !pc_load_r))
    else $error("untaken branch not single cycle");

  squash_pair_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    squash_r == pc_load_r)
    else $error("squash and load out of step");

  squash_stall_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    squash_r |-> stall_r)
    else $error("squash without extra slot");

  load_pulse_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    pc_load_r |=> !pc_load_r)
    else $error("load pulse longer than one cycle");

  busy_ignore_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (insn_valid && is_branch && state_r != CBU_IDLE) |=> !pc_load_r)
    else $error("branch taken during extra slots");

  non_branch_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (insn_valid && !is_branch && state_r == CBU_IDLE) |=> (!pc_load_r && !branch_done_r && !stall_r))
    else $error("non branch word acted on");

  branch_outcome_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    accept |=> (branch_taken_r == pc_load_r))
    else $error("outcome and load disagree");

  idle_quiet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == CBU_IDLE && !take) |=> !stall_r)
    else $error("stall without taken branch");

  flush_no_done_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == CBU_FLUSH && slot_cnt_r != cbu_pkg::CNT_ONE) |=> !branch_done_r)
    else $error("branch done too early");

  target_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !take |=> $stable(pc_target_r))
    else $error("target changed without taken branch");

  stall_run_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    stall_r |-> (stall_run_r < EXTRA_SLOTS))
    else $error("stall run too long");

  stall_end_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(stall_r) |-> (branch_done_r && stall_run_r == EXTRA_SLOTS))
    else $error("stall run length wrong");

endmodule

// ---- src/cbu_pkg.sv ----
package cbu_pkg;

  // ----------------------------------------
  // Instruction word layout
  // ----------------------------------------
  localparam int unsigned INSN_W = 24;
  localparam int unsigned PC_W = 24;
  localparam int unsigned OFFSET_W = 16;
  localparam int unsigned OP_HI_MSB = 23;
  localparam int unsigned OP_HI_LSB = 20;
  localparam int unsigned OP_LO_MSB = 19;
  localparam int unsigned OP_LO_LSB = 16;
  localparam int unsigned OFF_MSB = 15;
  localparam int unsigned OFF_LSB = 0;

  // ----------------------------------------
  // Opcode nibbles
  // ----------------------------------------
  localparam logic [3:0] OP_BRANCH_GROUP = 4'h3;
  localparam logic [3:0] OP_UNSIGNED_ABOVE = 4'hE;
  localparam logic [3:0] OP_SIGNED_AT_MOST = 4'h4;
  localparam logic [3:0] OP_UNSIGNED_AT_MOST = 4'h6;
  localparam logic [3:0] OP_SIGNED_BELOW = 4'h5;

  // ----------------------------------------
  // Program counter and timing
  // ----------------------------------------
  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam logic [23:0] PC_RESET = 24'h000000;
  localparam logic [23:0] NOP_WORD = 24'h000000;
  localparam int unsigned TAKEN_CYCLES_BASIC = 2;
  localparam int unsigned TAKEN_CYCLES_ENHANCED = 4;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;

  typedef enum logic [1:0]
  {
    CBU_NONE,
    CBU_UA,
    CBU_SM,
    CBU_UM
  } cbu_dummy_type;

endpackage

// ---- src/cbu_cond_eval.sv ----
`timescale 1ns/100ps
module cbu_cond_eval
(
  input wire logic [3:0] op_hi,
  input wire logic [3:0] op_lo,
  input wire logic flag_c,
  input wire logic flag_z,
  input wire logic flag_n,
  input wire logic flag_ov,
  output logic is_branch,
  output logic cond_true
);
  logic sign_diff;

  assign sign_diff = flag_n ^ flag_ov;

  always_comb
  begin
    is_branch = 1'b0;
    cond_true = 1'b0;
    if (op_hi == cbu_pkg::OP_BRANCH_GROUP)
    begin
      case (op_lo)
        cbu_pkg::OP_UNSIGNED_ABOVE:
        begin
          is_branch = 1'b1;
          cond_true = flag_c && !flag_z;
        end
        cbu_pkg::OP_SIGNED_AT_MOST:
        begin
          is_branch = 1'b1;
          cond_true = flag_z || sign_diff;
        end
        cbu_pkg::OP_UNSIGNED_AT_MOST:
        begin
          is_branch = 1'b1;
          cond_true = !flag_c || flag_z;
        end
        cbu_pkg::OP_SIGNED_BELOW:
        begin
          is_branch = 1'b1;
          cond_true = sign_diff;
        end
        default:
        begin
          is_branch = 1'b0;
          cond_true = 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- src/cbu_target.sv ----
`timescale 1ns/100ps
module cbu_target
#(
  parameter int unsigned PC_W = 24,
  parameter int unsigned OFFSET_W = 16
)
(
  input wire logic [PC_W-1:0] pc,
  input wire logic [OFFSET_W-1:0] offset,
  output logic [PC_W-1:0] target
);
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] word_offset;

  // Offset counts words from the following instruction
  assign next_pc = pc + PC_W'(cbu_pkg::PC_STEP);
  // Sign extend then double; full 16-bit two's complement range
  assign word_offset = {{(PC_W-OFFSET_W-1){offset[OFFSET_W-1]}}, offset, 1'b0};
  assign target = next_pc + word_offset;
endmodule

// ---- tb/cbu_fetch_model.sv ----
`timescale 1ns/100ps
module cbu_fetch_model
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] flag_set,
  input wire logic pc_load_r,
  input wire logic [23:0] pc_target_r,
  output logic flag_c,
  output logic flag_z,
  output logic flag_n,
  output logic flag_ov,
  output logic [23:0] fetch_pc_r
);
  // ----------------------------------------
  // Flag word, read only by the branch unit
  // ----------------------------------------
  assign {flag_c, flag_z, flag_n, flag_ov} = flag_set;

  // ----------------------------------------
  // Fetch counter follows redirects only
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      fetch_pc_r <= 24'h000000;
    else if (pc_load_r)
      fetch_pc_r <= pc_target_r;
  end
endmodule

// ---- tb/conditional_branch_unit_tb.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (a), (e)); end end
module conditional_branch_unit_tb;
  typedef struct {logic [23:0] w; logic [23:0] p; logic [3:0] f; int k; logic [23:0] t;} cbu_row_type;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk, arst_n, insn_valid;
  logic [23:0] insn_word, insn_pc, pc_target_r, ir_nop_r, fetch_pc_r;
  logic [3:0] flag_set;
  logic flag_c, flag_z, flag_n, flag_ov;
  logic pc_load_r, squash_r, stall_r, branch_done_r, branch_taken_r;
  logic pc_load_e, squash_e, stall_e, done_e, taken_e;
  logic [23:0] pc_target_e;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  // Flags {c,z,n,ov}; kind 0 ignored, 1 untaken, 2 taken
  cbu_row_type rows[11] = '{
    '{24'h3E0003, 24'h002000, 4'h8, 2, 24'h002008},
    '{24'h3E0003, 24'h002000, 4'hC, 1, 24'h000000},
    '{24'h34FFFC, 24'h007608, 4'h4, 2, 24'h007602},
    '{24'h340000, 24'h002000, 4'h2, 2, 24'h002002},
    '{24'h340005, 24'h002000, 4'h8, 1, 24'h000000},
    '{24'h367FFF, 24'h000000, 4'h0, 2, 24'h010000},
    '{24'h360001, 24'h002000, 4'h8, 1, 24'h000000},
    '{24'h358000, 24'h010000, 4'h1, 2, 24'h000002},
    '{24'h350001, 24'h002000, 4'h2, 2, 24'h002004},
    '{24'h350000, 24'h002000, 4'h3, 1, 24'h000000},
    '{24'h3D0003, 24'h002000, 4'h8, 0, 24'h000000}};

  cbu_top #(.ENHANCED(1'b0), .PC_W(24), .INSN_W(24)) DUT
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .insn_valid(insn_valid),
    .insn_word(insn_word),
    .insn_pc(insn_pc),
    .flag_c(flag_c),
    .flag_z(flag_z),
    .flag_n(flag_n),
    .flag_ov(flag_ov),
    .pc_load_r(pc_load_r),
    .pc_target_r(pc_target_r),
    .squash_r(squash_r),
    .ir_nop_r(ir_nop_r),
    .stall_r(stall_r),
    .branch_done_r(branch_done_r),
    .branch_taken_r(branch_taken_r)
  );

  cbu_top #(.ENHANCED(1'b1), .PC_W(24), .INSN_W(24)) DUT_ENH
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .insn_valid(insn_valid),
    .insn_word(insn_word),
    .insn_pc(insn_pc),
    .flag_c(flag_c),
    .flag_z(flag_z),
    .flag_n(flag_n),
    .flag_ov(flag_ov),
    .pc_load_r(pc_load_e),
    .pc_target_r(pc_target_e),
    .squash_r(squash_e),
    .ir_nop_r(),
    .stall_r(stall_e),
    .branch_done_r(done_e),
    .branch_taken_r(taken_e)
  );

  cbu_fetch_model partner
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .flag_set(flag_set),
    .pc_load_r(pc_load_r),
    .pc_target_r(pc_target_r),
    .flag_c(flag_c),
    .flag_z(flag_z),
    .flag_n(flag_n),
    .flag_ov(flag_ov),
    .fetch_pc_r(fetch_pc_r)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Closing and hang guard
  // ----------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run is under a hundred cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      report_and_stop();
    end
  end

  // One instruction, then wait out its slots
  task automatic run_row(input cbu_row_type r);
    insn_word = r.w;
    insn_pc = r.p;
    flag_set = r.f;
    insn_valid = 1'b1;
    @(posedge core_clk);
    #1;
    insn_valid = 1'b0;
    `CHK(pc_load_r, 1'(r.k == 2))
    `CHK(squash_r, 1'(r.k == 2))
    `CHK(branch_done_r, 1'(r.k == 1))
    `CHK(stall_r, 1'(r.k == 2))
    `CHK(pc_load_e, 1'(r.k == 2))
    `CHK(squash_e, 1'(r.k == 2))
    `CHK(stall_e, 1'(r.k == 2))
    `CHK(done_e, 1'(r.k == 1))
    if (r.k == 2)
    begin
      `CHK(pc_target_r, r.t)
      `CHK(pc_target_e, r.t)
      `CHK(ir_nop_r, cbu_pkg::NOP_WORD)
      n = 0;
      while (branch_done_r !== 1'b1 && n < 10)
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
      `CHK(n, cbu_pkg::TAKEN_CYCLES_BASIC - 1)
      `CHK(fetch_pc_r, r.t)
      while (done_e !== 1'b1 && n < 10)
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
      `CHK(n, cbu_pkg::TAKEN_CYCLES_ENHANCED - 1)
    end
    if (r.k != 0)
    begin
      `CHK(branch_taken_r, 1'(r.k == 2))
      `CHK(taken_e, 1'(r.k == 2))
    end
    @(posedge core_clk);
    #1;
  endtask

  initial
  begin
    arst_n = 1'b0;
    insn_valid = 1'b0;
    insn_word = 24'h000000;
    insn_pc = 24'h000000;
    flag_set = 4'h0;
    repeat (6) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    `CHK(stall_r, 1'b0)
    for (int i = 0; i < 11; i++)
    begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // Second branch word presented during the extra slot is not taken
    insn_word = 24'h3E0003;
    insn_pc = 24'h002000;
    flag_set = 4'h8;
    insn_valid = 1'b1;
    @(posedge core_clk);
    #1;
    insn_word = 24'h3E0010;
    @(posedge core_clk);
    #1;
    insn_valid = 1'b0;
    `CHK(pc_load_r, 1'b0)
    `CHK(branch_done_r, 1'b1)
    `CHK(pc_load_e, 1'b0)
    @(posedge core_clk);
    #1;
    `CHK(pc_target_r, 24'h002008)
    $display("stall test done");
    // Reset in mid branch clears the extra slot at once
    insn_valid = 1'b1;
    @(posedge core_clk);
    #1;
    insn_valid = 1'b0;
    arst_n = 1'b0;
    #1;
    `CHK(stall_r, 1'b0)
    `CHK(pc_load_r, 1'b0)
    `CHK(stall_e, 1'b0)
    @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    `CHK(branch_done_r, 1'b0)
    run_row(rows[0]);
    $display("reset test done");
    report_and_stop();
  end
endmodule
